// ---- common/sqdr_pkg.sv ----
// Package: register map, field layout and reset values of the loop diagnostic registers.
// Assumes a single 125 MHz core clock domain.
`default_nettype none
package sqdr_pkg;
  localparam logic [6:0]  REQ_ADDR       = 7'h38;
  localparam logic [6:0]  RES_ADDR       = 7'h37;
  localparam int          REG_W          = 20;
  localparam logic [19:0] REQ_RESET      = 20'h00007;
  localparam logic [19:0] RES_RESET      = 20'h00000;
  // Request register field positions
  localparam int          LEAK_LSB       = 0;
  localparam int          RES_LSB        = 4;
  localparam int          REGULATOR_CURRENT_MONITOR_LSB       = 8;
  localparam int          SINK_BIT       = 10;
  localparam int          SRC_LSB        = 11;
  localparam int          PD_BIT         = 13;
  localparam int          CUR_SEL_BIT    = 14;
  localparam int          DEPTH_BIT      = 15;
  // Result register field positions
  localparam int          R_LEAK_LSB     = 0;
  localparam int          R_PIN_BIT      = 4;
  localparam int          R_BAT_BIT      = 5;
  localparam int          R_GND_BIT      = 6;
  localparam int          R_SHORT_BIT    = 7;
  localparam int          NUM_CH         = 4;
  localparam logic [1:0]  SRC_SEL_ONLY   = 2'h2;
  localparam logic [1:0]  SRC_ALL_OFF    = 2'h3;
  localparam int          SYNC_STAGES    = 2;
endpackage
`default_nettype wire

// ---- hdl/sqdr_chan_decode.sv ----
// Channel select decoder: four-bit code to one-hot channel vector.
// Assumes codes above 3 select no channel.
`default_nettype none
module sqdr_chan_decode (
  input  wire logic [3:0] code,
  output logic      [3:0] onehot
);
  always_comb begin
    onehot = 4'h0;
    if (code < 4'h4) begin
      onehot[code[1:0]] = 1'b1;
    end
  end
endmodule
`default_nettype wire

// ---- hdl/sqdr_sync.sv ----
// Two-flop synchroniser for asynchronous level inputs.
// Assumes the input is a slow level.
`default_nettype none
module sqdr_sync #(
  parameter int W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] stage1;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= '0;
      q      <= '0;
    end else begin
      stage1 <= d;
      q      <= stage1;
    end
  end
endmodule
`default_nettype wire

// ---- hdl/sqdr_regs.sv ----
// Loop diagnostic result and low-level request registers with derived channel controls.
// Assumes a same-clock serial frame decoder delivers word writes and read strobes.
//
// How it works
// - Loop-to-loop short flag reads 1 when a short between loops was found.
// - Ground fault flag reads 1 when a short to ground was detected.
// - Battery fault flag reads 1 when a short to battery was detected.
// - Result fields clear on soft reset, else change only on diagnostic writes.
// - Loop pin side from leakage diagnostic: 0 return pin, 1 feed pin.
// - Leakage channel code 0 to 3 selects a channel, higher selects none.
// - Pulldown bit 0 disables only monitored/sink/source channels; 1 disables all.
// - Pulldown and source fields change only by soft reset or host write.
// - Two-bit source control, reset 00, drives the resistance-selected channel.
// - Source 10 enables only the selected channel; 11 disables everywhere.
// - Resistance channel code 0 to 3 selects a channel, higher selects none.
// - Depth select: 0 low level, 1 high level; soft reset or host write.
`default_nettype none
module sqdr_regs (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        soft_system_reset,
  input  wire logic        host_wr,
  input  wire logic        host_rd,
  input  wire logic [6:0]  host_addr,
  input  wire logic [19:0] host_wdata,
  input  wire logic        diag_result_we,
  input  wire logic        loop_to_loop_short_in,
  input  wire logic        ground_fault_in,
  input  wire logic        battery_fault_in,
  input  wire logic        leak_result_we,
  input  wire logic        loop_pin_side_in,
  input  wire logic [3:0]  leakage_channel_in,
  input  wire logic        ground_fault_leak_in,
  input  wire logic        battery_fault_leak_in,
  output logic      [19:0] host_rdata,
  output logic             host_rvalid,
  output logic             loop_to_loop_short_flag,
  output logic             ground_fault_flag,
  output logic             battery_fault_flag,
  output logic             loop_pin_side,
  output logic      [3:0]  leakage_channel_select,
  output logic             diagnostic_depth_select,
  output logic             source_current_value_select,
  output logic             pulldown_control,
  output logic      [1:0]  high_side_source_control,
  output logic             low_side_sink_control,
  output logic      [1:0]  regulator_current_monitor,
  output logic      [3:0]  resistance_channel_select,
  output logic      [3:0]  req_leakage_channel,
  output logic      [3:0]  source_enable,
  output logic      [3:0]  sink_enable,
  output logic      [3:0]  pulldown_disable
);
  logic       rst_q1;
  logic       rst_n;
  logic       soft_sync;
  logic       req_hit;
  logic [3:0] res_onehot;
  logic [3:0] leak_onehot;
  logic [3:0] next_source_enable;
  logic [3:0] next_sink_enable;
  logic [3:0] next_pulldown_disable;
  logic [19:0] next_host_rdata;

  // Reset release through two flops
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
    end
  end

  // Soft reset arrives from the system state machine asynchronously
  sqdr_sync #(
    .W (1)
  ) u_soft_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .d        (soft_system_reset),
    .q        (soft_sync)
  );

  // Request register address match, shared by write and readback
  function automatic logic is_req_addr(input logic [6:0] addr);
    return addr == sqdr_pkg::REQ_ADDR;
  endfunction

  assign req_hit = host_wr && is_req_addr(host_addr);

  // Result: loop diagnostic fields
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      loop_to_loop_short_flag <= 1'b0;
    end else if (soft_sync) begin
      loop_to_loop_short_flag <= 1'b0;
    end else if (diag_result_we) begin
      loop_to_loop_short_flag <= loop_to_loop_short_in;
    end
  end

  // Result: ground fault flag, written by either diagnostic
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ground_fault_flag <= 1'b0;
    end else if (soft_sync) begin
      ground_fault_flag <= 1'b0;
    end else if (diag_result_we) begin
      ground_fault_flag <= ground_fault_in;
    end else if (leak_result_we) begin
      ground_fault_flag <= ground_fault_leak_in;
    end
  end

  // Result: battery fault flag, written by either diagnostic
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      battery_fault_flag <= 1'b0;
    end else if (soft_sync) begin
      battery_fault_flag <= 1'b0;
    end else if (diag_result_we) begin
      battery_fault_flag <= battery_fault_in;
    end else if (leak_result_we) begin
      battery_fault_flag <= battery_fault_leak_in;
    end
  end

  // Result: pin side from leakage diagnostic
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      loop_pin_side <= 1'b0;
    end else if (soft_sync) begin
      loop_pin_side <= 1'b0;
    end else if (leak_result_we) begin
      loop_pin_side <= loop_pin_side_in;
    end
  end

  // Result: leakage channel from leakage diagnostic
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      leakage_channel_select <= 4'h0;
    end else if (soft_sync) begin
      leakage_channel_select <= 4'h0;
    end else if (leak_result_we) begin
      leakage_channel_select <= leakage_channel_in;
    end
  end

  // Request: diagnostic depth
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      diagnostic_depth_select <= sqdr_pkg::REQ_RESET[sqdr_pkg::DEPTH_BIT];
    end else if (soft_sync) begin
      diagnostic_depth_select <= sqdr_pkg::REQ_RESET[sqdr_pkg::DEPTH_BIT];
    end else if (req_hit) begin
      diagnostic_depth_select <= host_wdata[sqdr_pkg::DEPTH_BIT];
    end
  end

  // Request: source current value
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      source_current_value_select <= sqdr_pkg::REQ_RESET[sqdr_pkg::CUR_SEL_BIT];
    end else if (soft_sync) begin
      source_current_value_select <= sqdr_pkg::REQ_RESET[sqdr_pkg::CUR_SEL_BIT];
    end else if (req_hit) begin
      source_current_value_select <= host_wdata[sqdr_pkg::CUR_SEL_BIT];
    end
  end

  // Request: pulldown control
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pulldown_control <= sqdr_pkg::REQ_RESET[sqdr_pkg::PD_BIT];
    end else if (soft_sync) begin
      pulldown_control <= sqdr_pkg::REQ_RESET[sqdr_pkg::PD_BIT];
    end else if (req_hit) begin
      pulldown_control <= host_wdata[sqdr_pkg::PD_BIT];
    end
  end

  // Request: high side source control
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      high_side_source_control <= sqdr_pkg::REQ_RESET[sqdr_pkg::SRC_LSB +: 2];
    end else if (soft_sync) begin
      high_side_source_control <= sqdr_pkg::REQ_RESET[sqdr_pkg::SRC_LSB +: 2];
    end else if (req_hit) begin
      high_side_source_control <= host_wdata[sqdr_pkg::SRC_LSB +: 2];
    end
  end

  // Request: low side sink control
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_side_sink_control <= sqdr_pkg::REQ_RESET[sqdr_pkg::SINK_BIT];
    end else if (soft_sync) begin
      low_side_sink_control <= sqdr_pkg::REQ_RESET[sqdr_pkg::SINK_BIT];
    end else if (req_hit) begin
      low_side_sink_control <= host_wdata[sqdr_pkg::SINK_BIT];
    end
  end

  // Request: regulator current monitor
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      regulator_current_monitor <= sqdr_pkg::REQ_RESET[sqdr_pkg::REGULATOR_CURRENT_MONITOR_LSB +: 2];
    end else if (soft_sync) begin
      regulator_current_monitor <= sqdr_pkg::REQ_RESET[sqdr_pkg::REGULATOR_CURRENT_MONITOR_LSB +: 2];
    end else if (req_hit) begin
      regulator_current_monitor <= host_wdata[sqdr_pkg::REGULATOR_CURRENT_MONITOR_LSB +: 2];
    end
  end

  // Request: resistance channel select
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      resistance_channel_select <= sqdr_pkg::REQ_RESET[sqdr_pkg::RES_LSB +: 4];
    end else if (soft_sync) begin
      resistance_channel_select <= sqdr_pkg::REQ_RESET[sqdr_pkg::RES_LSB +: 4];
    end else if (req_hit) begin
      resistance_channel_select <= host_wdata[sqdr_pkg::RES_LSB +: 4];
    end
  end

  // Request: leakage channel select
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_leakage_channel <= sqdr_pkg::REQ_RESET[sqdr_pkg::LEAK_LSB +: 4];
    end else if (soft_sync) begin
      req_leakage_channel <= sqdr_pkg::REQ_RESET[sqdr_pkg::LEAK_LSB +: 4];
    end else if (req_hit) begin
      req_leakage_channel <= host_wdata[sqdr_pkg::LEAK_LSB +: 4];
    end
  end

  // Channel decodes
  sqdr_chan_decode u_res_dec (
    .code   (resistance_channel_select),
    .onehot (res_onehot)
  );

  sqdr_chan_decode u_leak_dec (
    .code   (req_leakage_channel),
    .onehot (leak_onehot)
  );

  // Per-channel current controls; source codes other than 10 keep the source off
  for (genvar ch = 0; ch < sqdr_pkg::NUM_CH; ch++) begin : g_chan
    logic monitor_on;
    assign monitor_on                = (regulator_current_monitor != 2'h0) && leak_onehot[ch];
    assign next_source_enable[ch]    = (high_side_source_control == sqdr_pkg::SRC_SEL_ONLY)
                                       && res_onehot[ch];
    assign next_sink_enable[ch]      = low_side_sink_control && res_onehot[ch];
    assign next_pulldown_disable[ch] = pulldown_control || next_source_enable[ch]
                                       || next_sink_enable[ch] || monitor_on;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      source_enable    <= 4'h0;
      sink_enable      <= 4'h0;
      pulldown_disable <= 4'h0;
    end else begin
      source_enable    <= next_source_enable;
      sink_enable      <= next_sink_enable;
      pulldown_disable <= next_pulldown_disable;
    end
  end

  // Readback word for the addressed register; unmapped reads return zero
  always_comb begin
    next_host_rdata = 20'h00000;
    if (is_req_addr(host_addr)) begin
      next_host_rdata = {4'h0, diagnostic_depth_select, source_current_value_select, pulldown_control,
                         high_side_source_control, low_side_sink_control, regulator_current_monitor,
                         resistance_channel_select, req_leakage_channel};
    end else if (host_addr == sqdr_pkg::RES_ADDR) begin
      next_host_rdata = {12'h000, loop_to_loop_short_flag, ground_fault_flag, battery_fault_flag,
                         loop_pin_side, leakage_channel_select};
    end
  end

  // Read strobe answered one cycle later
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      host_rvalid <= 1'b0;
    end else begin
      host_rvalid <= host_rd;
    end
  end

  // Read data stands until the next read
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      host_rdata <= 20'h00000;
    end else if (host_rd) begin
      host_rdata <= next_host_rdata;
    end
  end
endmodule
`default_nettype wire

// ---- verification/sqdr_regs_asserts.sv ----
// Checker for the loop diagnostic register block.
// Assumes one core clock and the active-low reset at the ports.
`default_nettype none
module sqdr_regs_asserts (
  input wire logic        core_clk,
  input wire logic        resetn,
  input wire logic        soft_system_reset,
  input wire logic        host_wr,
  input wire logic        host_rd,
  input wire logic [6:0]  host_addr,
  input wire logic [19:0] host_wdata,
  input wire logic        diag_result_we,
  input wire logic        leak_result_we,
  input wire logic        loop_to_loop_short_in,
  input wire logic        ground_fault_in,
  input wire logic        battery_fault_in,
  input wire logic        host_rvalid,
  input wire logic        loop_to_loop_short_flag,
  input wire logic        ground_fault_flag,
  input wire logic        battery_fault_flag,
  input wire logic        loop_pin_side,
  input wire logic [3:0]  leakage_channel_select,
  input wire logic        diagnostic_depth_select,
  input wire logic        pulldown_control,
  input wire logic [1:0]  high_side_source_control,
  input wire logic [3:0]  source_enable,
  input wire logic [3:0]  pulldown_disable
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence quiet;
    !soft_system_reset [*4];
  endsequence
  sequence req_wr;
    host_wr && host_addr == sqdr_pkg::REQ_ADDR;
  endsequence
  a_rvalid_after_rd: assert property (host_rd |=> host_rvalid) else $error("read not answered");
  a_req_write_load: assert property (quiet ##0 req_wr |=> pulldown_control == $past(host_wdata[13]) &&
    high_side_source_control == $past(host_wdata[12:11]) && diagnostic_depth_select == $past(host_wdata[15]))
    else $error("request fields not loaded");
  a_fault_flag_load: assert property (quiet ##0 diag_result_we |=> ground_fault_flag == $past(ground_fault_in) &&
    battery_fault_flag == $past(battery_fault_in) && loop_to_loop_short_flag == $past(loop_to_loop_short_in))
    else $error("fault flags not loaded");
  a_flags_hold_idle: assert property (quiet ##0 !diag_result_we && !leak_result_we |=>
    $stable(ground_fault_flag) && $stable(battery_fault_flag) && $stable(loop_to_loop_short_flag) &&
    $stable(loop_pin_side) && $stable(leakage_channel_select)) else $error("result changed unprompted");
  a_source_all_off: assert property ((high_side_source_control == sqdr_pkg::SRC_ALL_OFF) [*2] |->
    source_enable == 4'h0) else $error("source on while off");
  a_pulldown_all: assert property (pulldown_control [*2] |-> pulldown_disable == 4'hF)
    else $error("pulldown not off everywhere");
  a_soft_clear_all: assert property (soft_system_reset [*4] |-> !ground_fault_flag && !battery_fault_flag &&
    !loop_to_loop_short_flag && !loop_pin_side && !pulldown_control && high_side_source_control == 2'h0)
    else $error("soft reset did not clear");
  a_depth_soft_clear: assert property (soft_system_reset [*4] |-> !diagnostic_depth_select)
    else $error("depth not cleared");
endmodule
bind sqdr_regs sqdr_regs_asserts u_sqdr_regs_asserts (.*);
`default_nettype wire

// ---- verification/sqdr_host.sv ----
// Host model: register writes and reads on the serial port side.
// Assumes the block samples on the rising edge.
`default_nettype none
module sqdr_host (
  input  wire logic        core_clk,
  output var  logic        host_wr,
  output var  logic        host_rd,
  output var  logic [6:0]  host_addr,
  output var  logic [19:0] host_wdata,
  input  wire logic [19:0] host_rdata,
  input  wire logic        host_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_addr = 7'h00;
    host_wdata = 20'h00000;
  end
  task automatic wr(input logic [6:0] a, input logic [19:0] d);
    @(negedge core_clk);
    host_addr = a;
    host_wdata = d;
    host_wr = 1'b1;
    @(negedge core_clk);
    host_wr = 1'b0;
    host_wdata = ~d;
  endtask
  task automatic rd(input logic [6:0] a, output logic [19:0] d, output logic v);
    @(negedge core_clk);
    host_addr = a;
    host_rd = 1'b1;
    @(negedge core_clk);
    host_rd = 1'b0;
    v = host_rvalid;
    d = host_rdata;
  endtask
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
// Bench for the loop diagnostic registers with a host model.
// Assumes the checker is bound to the block.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        soft_system_reset = 1'b0;
  logic        dwe = 1'b0, lwe = 1'b0, s_in = 1'b0, g_in = 1'b0, b_in = 1'b0, p_in = 1'b0;
  logic [3:0]  ch_in = 4'h0;
  logic        host_wr, host_rd, host_rvalid;
  logic [6:0]  host_addr;
  logic [19:0] host_wdata, host_rdata;
  logic [3:0]  source_enable, sink_enable, pulldown_disable;
  wire logic [7:0]  res_flags;
  wire logic [15:0] req_fields;
  int          fails = 0;
  int          n_checks = 0;
  int          cyc = 0;
  always #4 core_clk = ~core_clk;
  sqdr_host u_sqdr_host (.core_clk(core_clk), .host_wr(host_wr), .host_rd(host_rd), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_rdata(host_rdata), .host_rvalid(host_rvalid));
  sqdr_regs u_sqdr_regs (.core_clk(core_clk), .resetn(resetn), .soft_system_reset(soft_system_reset),
    .host_wr(host_wr), .host_rd(host_rd), .host_addr(host_addr), .host_wdata(host_wdata),
    .diag_result_we(dwe), .loop_to_loop_short_in(s_in), .ground_fault_in(g_in), .battery_fault_in(b_in),
    .leak_result_we(lwe), .loop_pin_side_in(p_in), .leakage_channel_in(ch_in), .ground_fault_leak_in(g_in),
    .battery_fault_leak_in(b_in), .host_rdata(host_rdata), .host_rvalid(host_rvalid),
    .loop_to_loop_short_flag(res_flags[7]), .ground_fault_flag(res_flags[6]), .battery_fault_flag(res_flags[5]),
    .loop_pin_side(res_flags[4]), .leakage_channel_select(res_flags[3:0]),
    .diagnostic_depth_select(req_fields[15]), .source_current_value_select(req_fields[14]),
    .pulldown_control(req_fields[13]), .high_side_source_control(req_fields[12:11]),
    .low_side_sink_control(req_fields[10]), .regulator_current_monitor(req_fields[9:8]),
    .resistance_channel_select(req_fields[7:4]), .req_leakage_channel(req_fields[3:0]),
    .source_enable(source_enable), .sink_enable(sink_enable), .pulldown_disable(pulldown_disable));
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [20:0] exp, input logic [20:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rchk(input string nm, input logic [6:0] a, input logic [19:0] exp);
    logic [19:0] d;
    logic        v;
    u_sqdr_host.rd(a, d, v);
    chk(nm, {1'b1, exp}, {v, d});
    if (a == sqdr_pkg::RES_ADDR) begin
      chk({nm, " pins"}, {1'b0, exp}, {13'h0000, res_flags});
    end else if (a == sqdr_pkg::REQ_ADDR) begin
      chk({nm, " pins"}, {1'b0, exp}, {5'h00, req_fields});
    end
  endtask
  task automatic ev(input logic leak, input logic [7:0] v);
    @(negedge core_clk);
    {s_in, g_in, b_in, p_in, ch_in} = v;
    dwe = !leak;
    lwe = leak;
    @(negedge core_clk);
    dwe = 1'b0;
    lwe = 1'b0;
  endtask
  task automatic wr_en(input logic [19:0] d, input logic [3:0] src, input logic [3:0] snk, input logic [3:0] pd);
    u_sqdr_host.wr(sqdr_pkg::REQ_ADDR, d);
    repeat (2) @(negedge core_clk);
    chk("source_enable", {17'h0, src}, {17'h0, source_enable});
    chk("sink_enable", {17'h0, snk}, {17'h0, sink_enable});
    chk("pulldown_disable", {17'h0, pd}, {17'h0, pulldown_disable});
    rchk("request", sqdr_pkg::REQ_ADDR, d & 20'h0FFFF);
  endtask
  task automatic t_reset;
    rchk("request reset", sqdr_pkg::REQ_ADDR, sqdr_pkg::REQ_RESET);
    rchk("result reset", sqdr_pkg::RES_ADDR, 20'h00000);
    rchk("unmapped", 7'h10, 20'h00000);
    $display("t_reset done");
  endtask
  task automatic t_results;
    ev(1'b0, 8'hA0);
    rchk("short and battery", sqdr_pkg::RES_ADDR, 20'h000A0);
    ev(1'b0, 8'h40);
    rchk("ground", sqdr_pkg::RES_ADDR, 20'h00040);
    ev(1'b1, 8'h33);
    rchk("leak feed ch3", sqdr_pkg::RES_ADDR, 20'h00033);
    ev(1'b1, 8'h4C);
    rchk("leak return none", sqdr_pkg::RES_ADDR, 20'h0004C);
    u_sqdr_host.wr(sqdr_pkg::RES_ADDR, 20'hFFFFF);
    rchk("result write ignored", sqdr_pkg::RES_ADDR, 20'h0004C);
    $display("t_results done");
  endtask
  task automatic t_request;
    wr_en(20'h01020, 4'h4, 4'h0, 4'h4);
    wr_en(20'h01050, 4'h0, 4'h0, 4'h0);
    wr_en(20'h01810, 4'h0, 4'h0, 4'h0);
    wr_en(20'h00512, 4'h0, 4'h2, 4'h6);
    wr_en(20'h02000, 4'h0, 4'h0, 4'hF);
    wr_en(20'hFB8F3, 4'h0, 4'h0, 4'hF);
    $display("t_request done");
  endtask
  task automatic t_soft;
    ev(1'b0, 8'hE0);
    @(negedge core_clk);
    soft_system_reset = 1'b1;
    repeat (5) @(negedge core_clk);
    soft_system_reset = 1'b0;
    repeat (3) @(negedge core_clk);
    rchk("soft request", sqdr_pkg::REQ_ADDR, sqdr_pkg::REQ_RESET);
    rchk("soft result", sqdr_pkg::RES_ADDR, 20'h00000);
    $display("t_soft done");
  endtask
  initial begin
    repeat (20) @(negedge core_clk);
    resetn = 1'b1;
    repeat (3) @(negedge core_clk);
    t_reset();
    t_results();
    t_request();
    t_soft();
    end_sim();
  end
endmodule
`default_nettype wire
